// ==== pdmbt_defs.vh ====
// Register offsets, field positions and codes for the PD message buffer block.
// Included by pdmbt_ctrl.v; definitions only.
`ifndef PDMBT_DEFS_VH
`define PDMBT_DEFS_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define PDMBT_ADDR_RX_COUNT 8'h30
`define PDMBT_ADDR_RX_KIND 8'h31
`define PDMBT_ADDR_RX_HDR_LO 8'h32
`define PDMBT_ADDR_RX_HDR_HI 8'h33
`define PDMBT_ADDR_RX_OBJ_FIRST 8'h34
`define PDMBT_ADDR_RX_OBJ_LAST 8'h4f
`define PDMBT_ADDR_TX_CMD 8'h50

// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define PDMBT_RESET_BYTE 8'h00
`define PDMBT_RX_OVERHEAD 8'h03
`define PDMBT_OBJ_BYTES 28
`define PDMBT_TX_CMD_MASK 8'h37
`define PDMBT_KIND_HARD_RESET 3'h5
`define PDMBT_KIND_CABLE_RESET 3'h6

`endif

// ==== pdmbt_ctrl.v ====
// PD message buffer and transmit control: receive buffer registers and
// transmit command register. Assumes a register access port already decoded
// from the serial host link, and a PHY that delivers messages and runs frames.
//
// Functional notes
// [RULE_01] Valid byte count equals object bytes plus three
// [RULE_02] Host reads only counted bytes
// [RULE_03] Received kind coded in three bits
// [RULE_04] Kind register upper five bits read zero
// [RULE_05] Header low then high byte, read only
// [RULE_06] Objects at 0x34 to 0x4F, one byte each
// [RULE_07] Command cleared when attempt finishes
// [RULE_08] Alert flag set at request discards packet
// [RULE_09] Two-bit retry count, zero to three retries
// [RULE_10] Transmit kind selected by three-bit field
// [RULE_11] Reserved command bits ignored by device
// [RULE_12] Fixed offsets, all reset to zero
// [RULE_13] Count cleared on hard reset, disconnect, alert clear
// [RULE_14] Host writes transmit byte count beforehand
// [RULE_15] Sending starts only after command write
// [RULE_16] Buffer updated only when alert flag clear
`timescale 1ns/1ps
`default_nettype none
`include "pdmbt_defs.vh"

module pdmbt_ctrl (
    // Clock and reset
    input wire clk,
    input wire sys_rst,
    // Register access port
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    output reg [7:0] reg_rdata,
    // Received message from the PHY
    input wire rx_msg_valid,
    input wire [2:0] rx_msg_kind,
    input wire [15:0] rx_msg_header,
    input wire [4:0] rx_msg_obj_bytes,
    input wire rx_obj_we,
    input wire [4:0] rx_obj_idx,
    input wire [7:0] rx_obj_data,
    // Alert flag state and clear event from the alert block, plus disconnect and received hard reset events
    input wire rx_message_alert_flag,
    input wire rx_alert_cleared,
    input wire disconnect_detected,
    input wire rx_hard_reset,
    // Transmit request to the PHY
    output reg tx_start,
    output reg [2:0] tx_frame_kind,
    output reg [1:0] tx_retry_limit,
    output reg tx_retry,
    input wire tx_attempt_ok,
    input wire tx_attempt_fail,
    // Attempt outcome
    output reg tx_done,
    output reg tx_success,
    output reg tx_discarded
);

    // ----------------------------------------
    // States
    // ----------------------------------------
    localparam ST_IDLE = 3'b001;
    localparam ST_SEND = 3'b010;
    localparam ST_DONE = 3'b100;

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    reg [7:0] rx_valid_byte_total;
    reg [2:0] rx_frame_kind;
    reg [7:0] rx_header_low;
    reg [7:0] rx_header_high;
    reg [7:0] rx_object_bytes [0:`PDMBT_OBJ_BYTES-1];
    reg [7:0] tx_command;
    reg [2:0] state;
    reg [1:0] tries_left;
    reg [7:0] next_rdata;
    integer i;

    // Object byte index from a register address
    function [4:0] obj_index;
        input [7:0] a;
        reg [7:0] d;
        begin
            d = a - `PDMBT_ADDR_RX_OBJ_FIRST;
            obj_index = d[4:0];
        end
    endfunction

    // ----------------------------------------
    // Receive buffer
    // ----------------------------------------
    // A new message is taken only while the alert flag is clear, so the host
    // never sees a buffer change under it.
    wire rx_take = rx_msg_valid && !rx_message_alert_flag; // RULE_16
    // A discarded hard reset never reached the line, so it keeps the count
    wire tx_hard = (state == ST_DONE) && !tx_discarded &&
                   (tx_frame_kind == `PDMBT_KIND_HARD_RESET);

    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rx_valid_byte_total <= `PDMBT_RESET_BYTE; // RULE_12
            rx_frame_kind <= 3'h0;
            rx_header_low <= `PDMBT_RESET_BYTE;
            rx_header_high <= `PDMBT_RESET_BYTE;
            for (i = 0; i < `PDMBT_OBJ_BYTES; i = i + 1) begin
                rx_object_bytes[i] <= `PDMBT_RESET_BYTE;
            end
        end else begin
            if (rx_obj_we && !rx_message_alert_flag && rx_obj_idx < `PDMBT_OBJ_BYTES) begin
                rx_object_bytes[rx_obj_idx] <= rx_obj_data; // RULE_06
            end
            if (rx_take) begin
                rx_frame_kind <= rx_msg_kind; // RULE_03
                rx_header_low <= rx_msg_header[7:0]; // RULE_05
                rx_header_high <= rx_msg_header[15:8];
            end
            // A clear and a new message in one cycle: the clear wins since
            // the message arrives against a flag that is being dropped.
            if (rx_hard_reset || tx_hard || disconnect_detected || rx_alert_cleared) begin
                rx_valid_byte_total <= `PDMBT_RESET_BYTE; // RULE_13
            end else if (rx_take) begin
                rx_valid_byte_total <= {3'b000, rx_msg_obj_bytes} + `PDMBT_RX_OVERHEAD; // RULE_01
            end
        end
    end

    // ----------------------------------------
    // Register read
    // ----------------------------------------
    always @* begin
        next_rdata = 8'h00;
        if (reg_rd) begin
            if (reg_addr == `PDMBT_ADDR_RX_COUNT) begin
                next_rdata = rx_valid_byte_total;
            end else if (reg_addr == `PDMBT_ADDR_RX_KIND) begin
                next_rdata = {5'h00, rx_frame_kind}; // RULE_04
            end else if (reg_addr == `PDMBT_ADDR_RX_HDR_LO) begin
                next_rdata = rx_header_low;
            end else if (reg_addr == `PDMBT_ADDR_RX_HDR_HI) begin
                next_rdata = rx_header_high;
            end else if (reg_addr >= `PDMBT_ADDR_RX_OBJ_FIRST &&
                         reg_addr <= `PDMBT_ADDR_RX_OBJ_LAST) begin
                next_rdata = rx_object_bytes[obj_index(reg_addr)]; // RULE_06
            end else if (reg_addr == `PDMBT_ADDR_TX_CMD) begin
                next_rdata = tx_command;
            end
        end
    end

    // Read data comes from a flop: it stands one cycle after the address,
    // which costs a cycle per read but keeps the host port free of glitches.
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            reg_rdata <= `PDMBT_RESET_BYTE;
        end else begin
            reg_rdata <= next_rdata;
        end
    end

    // ----------------------------------------
    // Transmit control
    // ----------------------------------------
    wire cmd_wr = reg_wr && (reg_addr == `PDMBT_ADDR_TX_CMD);

    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            tx_command <= `PDMBT_RESET_BYTE;
            state <= ST_IDLE;
            tries_left <= 2'b00;
            tx_start <= 1'b0;
            tx_retry <= 1'b0;
            tx_frame_kind <= 3'h0;
            tx_retry_limit <= 2'b00;
            tx_done <= 1'b0;
            tx_success <= 1'b0;
            tx_discarded <= 1'b0;
        end else begin
            tx_start <= 1'b0;
            tx_retry <= 1'b0;
            tx_done <= 1'b0;
            case (state)
                ST_IDLE: begin
                    if (cmd_wr) begin
                        // Reserved bits dropped so they never steer the PHY
                        tx_command <= reg_wdata & `PDMBT_TX_CMD_MASK; // RULE_11
                        tx_frame_kind <= reg_wdata[2:0]; // RULE_10
                        tx_retry_limit <= reg_wdata[5:4];
                        tries_left <= reg_wdata[5:4]; // RULE_09
                        if (rx_message_alert_flag) begin
                            tx_discarded <= 1'b1; // RULE_08
                            tx_success <= 1'b0;
                            state <= ST_DONE;
                        end else begin
                            tx_discarded <= 1'b0;
                            // Old outcome dropped so a pending attempt never reads as passed
                            tx_success <= 1'b0;
                            tx_start <= 1'b1; // RULE_15
                            state <= ST_SEND;
                        end
                    end
                end
                ST_SEND: begin
                    if (tx_attempt_ok) begin
                        tx_success <= 1'b1;
                        state <= ST_DONE;
                    end else if (tx_attempt_fail) begin
                        if (tries_left != 2'b00) begin
                            tries_left <= tries_left - 2'b01; // RULE_09
                            tx_retry <= 1'b1;
                        end else begin
                            tx_success <= 1'b0;
                            state <= ST_DONE;
                        end
                    end
                end
                ST_DONE: begin
                    tx_command <= `PDMBT_RESET_BYTE; // RULE_07
                    tx_done <= 1'b1;
                    state <= ST_IDLE;
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

endmodule
`default_nettype wire

// ==== pdmbt_sva.sv ====
// Checker for pdmbt_ctrl: transmit command and receive register relations.
// Sees only top ports; one clock, asynchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module pdmbt_sva (
    // Clock and reset
    input wire clk,
    input wire sys_rst,
    // Register port
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire [7:0] reg_rdata,
    // Transmit path
    input wire rx_message_alert_flag,
    input wire tx_start,
    input wire tx_retry,
    input wire [2:0] tx_frame_kind,
    input wire [1:0] tx_retry_limit,
    input wire tx_attempt_ok,
    input wire tx_attempt_fail,
    input wire tx_done,
    input wire tx_success,
    input wire tx_discarded
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    logic busy;
    logic [1:0] retry_cnt;
    wire cmd_wr = reg_wr && reg_addr == 8'h50 && (!busy || tx_done);
    // Open command tracked so that writes ignored while busy are not checked;
    // the design is idle again in the cycle that shows tx_done
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst)
            busy <= 1'b0;
        else if (cmd_wr)
            busy <= 1'b1;
        else if (tx_done)
            busy <= 1'b0;
    end
    // Resends counted per command against the retry field
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst)
            retry_cnt <= 2'h0;
        else if (cmd_wr)
            retry_cnt <= 2'h0;
        else if (tx_retry)
            retry_cnt <= retry_cnt + 2'h1;
    end
    cmd_kind_a: assert property (cmd_wr && !rx_message_alert_flag
        |=> tx_start && tx_frame_kind == $past(reg_wdata[2:0])) else $error("bad kind");
    retry_field_a: assert property (cmd_wr
        |=> tx_retry_limit == $past(reg_wdata[5:4])) else $error("bad retry field");
    discard_a: assert property (cmd_wr && rx_message_alert_flag
        |=> !tx_start ##1 (tx_done && tx_discarded)) else $error("no discard");
    start_cause_a: assert property (tx_start |-> $past(cmd_wr))
        else $error("start without command");
    cmd_cleared_a: assert property (!busy && reg_rd && reg_addr == 8'h50
        |=> reg_rdata == 8'h00) else $error("command not cleared");
    kind_upper_a: assert property (reg_rd && reg_addr == 8'h31
        |=> reg_rdata[7:3] == 5'h00) else $error("kind upper bits set");
    ok_done_a: assert property (busy && tx_attempt_ok
        |-> ##[1:3] (tx_done && tx_success)) else $error("no done after ok");
    no_retry_a: assert property (busy && tx_attempt_fail && tx_retry_limit == 2'b00
        |-> ##[1:3] (tx_done && !tx_success)) else $error("retried without limit");
    retry_bound_a: assert property (tx_retry
        |-> retry_cnt < tx_retry_limit) else $error("too many retries");
    cover property (tx_done && tx_success);
    cover property (tx_done && tx_discarded);
    cover property (tx_done && !tx_success && !tx_discarded);
endmodule
bind pdmbt_ctrl pdmbt_sva u_sva (
    .clk(clk),
    .sys_rst(sys_rst),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata),
    .rx_message_alert_flag(rx_message_alert_flag),
    .tx_start(tx_start),
    .tx_retry(tx_retry),
    .tx_frame_kind(tx_frame_kind),
    .tx_retry_limit(tx_retry_limit),
    .tx_attempt_ok(tx_attempt_ok),
    .tx_attempt_fail(tx_attempt_fail),
    .tx_done(tx_done),
    .tx_success(tx_success),
    .tx_discarded(tx_discarded)
);
`default_nettype wire

// ==== pdmbt_phy_model.sv ====
// Far-side model answering each transmit attempt with ok or fail.
// The bench sets how many attempts fail and how slowly it answers.
`timescale 1ns/1ps
`default_nettype none
module pdmbt_phy_model (
    // Clock
    input wire clk,
    // Attempt requests
    input wire tx_start,
    input wire tx_retry,
    // Bench controls
    input wire [1:0] fails,
    input wire [1:0] slow,
    // Outcome pulses
    output logic tx_attempt_ok,
    output logic tx_attempt_fail
);
    int left;
    // Early attempts fail so that the retry count is exercised
    initial begin
        {tx_attempt_ok, tx_attempt_fail} = 2'b00;
        forever begin
            @(posedge clk);
            if (tx_start || tx_retry) begin
                if (tx_start)
                    left = fails;
                repeat (slow) @(posedge clk);
                #1;
                tx_attempt_fail = left > 0;
                tx_attempt_ok = left <= 0;
                left = left - 1;
                @(posedge clk);
                #1;
                {tx_attempt_ok, tx_attempt_fail} = 2'b00;
            end
        end
    end
endmodule
`default_nettype wire

// ==== pdmbt_ctrl_bench.sv ====
// Bench for pdmbt_ctrl: host accesses, received messages, far-side model.
// Assumes outputs launched from clk; inputs change 1 ns after the edge.
`timescale 1ns/1ps
`default_nettype none
module pdmbt_ctrl_bench;
    logic clk = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, rx_msg_valid = 1'b0;
    logic rx_obj_we = 1'b0, rx_message_alert_flag = 1'b0, rx_alert_cleared = 1'b0;
    logic disconnect_detected = 1'b0, rx_hard_reset = 1'b0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, rx_obj_data = 8'h00;
    logic [4:0] rx_obj_idx = 5'h00, rx_msg_obj_bytes = 5'h00;
    logic [2:0] rx_msg_kind = 3'h0;
    logic [15:0] rx_msg_header = 16'h0000;
    logic [1:0] fails = 2'h0, slow = 2'h0;
    wire tx_start, tx_retry, tx_done, tx_success, tx_discarded, tx_attempt_ok, tx_attempt_fail;
    wire [2:0] tx_frame_kind;
    wire [1:0] tx_retry_limit;
    wire [7:0] reg_rdata;
    int err_count = 0, checks = 0, i, k, n;
    logic [7:0] regs [8] = '{8'h30, 8'h31, 8'h32, 8'h33, 8'h34, 8'h4f, 8'h50, 8'h2f};
    int codes [6] = '{0, 1, 2, 3, 4, 6};
    pdmbt_ctrl uut (.*);
    pdmbt_phy_model phy (.*);
    always #2.5 clk = ~clk;
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk) #1;
        {reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
        @(posedge clk) #1;
        reg_wr = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk) #1;
        {reg_rd, reg_addr} = {1'b1, a};
        @(posedge clk) #1;
        chk(reg_rdata, e);
    endtask
    task automatic wait_done;
        for (i = 0; tx_done !== 1'b1 && i < 40; i++) @(posedge clk) #1;
        if (tx_done !== 1'b1) begin
            err_count++;
            $display("[ERR] %0t no completion", $time);
            wrap_up;
        end
    endtask
    task automatic msg(input logic [2:0] kd, input logic [4:0] nb);
        for (int j = 0; j < nb; j++) begin
            @(posedge clk) #1;
            {rx_obj_we, rx_obj_idx, rx_obj_data} = {1'b1, j[4:0], 8'ha0 ^ j[7:0]};
        end
        @(posedge clk) #1;
        {rx_obj_we, rx_msg_valid, rx_msg_kind, rx_msg_obj_bytes} = {2'b01, kd, nb};
        rx_msg_header = {8'hc3, 5'h11, kd};
        @(posedge clk) #1;
        rx_msg_valid = 1'b0;
    endtask
    initial begin
        repeat (20) @(posedge clk);
        #1 sys_rst = 1'b0;
        wr(8'h31, 8'hff);
        foreach (regs[j]) rd(regs[j], 8'h00);
        $display("reset test done");
        foreach (codes[c]) begin
            k = codes[c];
            n = (k == 6) ? 28 : 4 * k;
            msg(k[2:0], n[4:0]);
            rd(8'h30, 8'(n + 3));
            rd(8'h31, 8'(k));
            rd(8'h32, {5'h11, k[2:0]});
            rd(8'h33, 8'hc3);
            if (n > 0) rd(8'(51 + n), 8'(8'ha0 ^ (n - 1)));
            for (i = 0; i < n; i++) rd(8'(52 + i), 8'ha0 ^ 8'(i));
            rx_message_alert_flag = 1'b1;
            msg(~k[2:0], 5'h04);
            rd(8'h31, 8'(k));
            // Each of the three input clear sources is used on its own, so none hides another
            {rx_message_alert_flag, rx_hard_reset} = {1'b0, k == 6};
            {disconnect_detected, rx_alert_cleared} = {k == 4, k < 4};
            @(posedge clk) #1;
            {rx_hard_reset, disconnect_detected, rx_alert_cleared} = 3'b000;
            rd(8'h30, 8'h00);
        end
        $display("receive test done");
        for (k = 0; k < 8; k++) begin
            {fails, slow} = {k[2:1], 1'b0, k[0]};
            wr(8'h51, 8'h02);
            wr(8'h50, {2'b11, k[1:0], 1'b1, k[2:0]});
            rd(8'h50, {2'b00, k[1:0], 1'b0, k[2:0]});
            wait_done;
            chk({7'h00, tx_success}, {7'h00, k[2:1] <= k[1:0]});
            rd(8'h50, 8'h00);
        end
        $display("transmit test done");
        rx_message_alert_flag = 1'b1;
        wr(8'h50, 8'h02);
        wait_done;
        chk({7'h00, tx_discarded}, 8'h01);
        rd(8'h50, 8'h00);
        $display("discard test done");
        wrap_up;
    end
endmodule
`default_nettype wire
